// *** include/dlm_conv_if.sv ***
// Handshake between the phase sequencer and the two-sample converter sequencer.
`timescale 1ns/100ps
interface dlm_conv_if;
	logic start;
	logic multi_sample_convert;
	logic [dlm_pkg::GAP_W-1:0] gap;
	logic busy;
	logic done;
	logic [dlm_pkg::ADC_W-1:0] first_data;
	logic [dlm_pkg::ADC_W-1:0] second_data;
	modport ctl(output start, output multi_sample_convert, output gap, input busy, input done,
		input first_data, input second_data);
	modport seq(input start, input multi_sample_convert, input gap, output busy, output done,
		output first_data, output second_data);
endinterface

// *** include/dlm_pkg.sv ***
// Constants, register map and types shared by the LED multiplex sequencer.
// How it works
// - Each LED lit 500 times per second.
// - Period event starts phase, sets pin, bridge.
// - Phase start loads LED DAC with level.
// - Phase start loads offset DAC with DC.
// - Auto two-sample conversion, first then second stage.
// - Conversion done raises interrupt, LED DAC zeroed.
// - LED DAC routed to one pin, other released.
// - Bridge outputs complementary, one LED conducts.
// - Per-LED level steers first-stage sample into target range.
// - Samples sorted into red and infrared streams.
// - Second stage sampled 1000 per second, alternating.
package dlm_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 100_000_000;
	localparam int LED_RATE_HZ = 500;
	localparam int PHASE_CYCLES = CLK_HZ / (2 * LED_RATE_HZ);
	localparam int SAMPLE_GAP_NS = 1000;
	localparam int SAMPLE_GAP_CYCLES = (SAMPLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DAC_W = 12;
	localparam int ADC_W = 12;
	localparam int ADDR_W = 8;
	localparam int GAP_W = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_RED_LEVEL = 8'h08;
	localparam logic [7:0] OFS_IR_LEVEL = 8'h0C;
	localparam logic [7:0] OFS_RED_DC = 8'h10;
	localparam logic [7:0] OFS_IR_DC = 8'h14;
	localparam logic [7:0] OFS_TARGET = 8'h18;
	localparam logic [7:0] OFS_GAP = 8'h1C;
	localparam logic [7:0] OFS_RED_DATA = 8'h20;
	localparam logic [7:0] OFS_IR_DATA = 8'h24;
	localparam logic [7:0] OFS_INT_STATUS = 8'h28;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h2C;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MSC_BIT = 1;
	localparam int CTRL_LEVEL_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h2;
	localparam int TGT_LO_LSB = 0;
	localparam int TGT_HI_LSB = 16;
	localparam logic [31:0] TARGET_RESET = 32'h0A00_0600;
	localparam int DATA_SECOND_LSB = 0;
	localparam int DATA_FIRST_LSB = 16;
	localparam logic [11:0] LEVEL_RESET = 12'h800;
	localparam logic [11:0] LEVEL_STEP = 12'h001;
	localparam int DC_SHIFT = 4;
	localparam int EV_W = 4;
	localparam int EV_PHASE = 0;
	localparam int EV_DONE_RED = 1;
	localparam int EV_DONE_IR = 2;
	localparam int EV_OVERRUN = 3;
	localparam int ST_LED_IR = 0;
	localparam int ST_PHASE_ON = 1;
	localparam int ST_CONV_BUSY = 2;
	typedef enum logic [1:0] {CS_IDLE, CS_FIRST, CS_GAP, CS_SECOND} dlm_conv_state_e;
endpackage

// *** logic/dlm_conv_seq.sv ***
// Two-sample converter sequencer: first stage, then second stage.
`timescale 1ns/100ps
module dlm_conv_seq (
	input wire logic pclk,
	input wire logic presetn,
	dlm_conv_if.seq cif,
	output logic adc_start,
	output logic adc_channel,
	input wire logic adc_done,
	input wire logic [dlm_pkg::ADC_W-1:0] adc_data
);
	dlm_pkg::dlm_conv_state_e state_reg, state_next;
	logic [dlm_pkg::GAP_W-1:0] gap_reg, gap_next;
	logic [dlm_pkg::ADC_W-1:0] first_reg, first_next, second_reg, second_next;
	logic start_reg, start_next, chan_reg, chan_next, done_reg, done_next;

	always_comb begin
		state_next = state_reg;
		gap_next = gap_reg;
		first_next = first_reg;
		second_next = second_reg;
		start_next = 1'b0;
		chan_next = chan_reg;
		done_next = 1'b0;
		unique case (state_reg)
			dlm_pkg::CS_IDLE: begin
				if (cif.start) begin
					start_next = 1'b1;
					chan_next = 1'b0;
					state_next = dlm_pkg::CS_FIRST;
				end
			end
			dlm_pkg::CS_FIRST: begin
				if (adc_done && !start_reg) begin
					first_next = adc_data;
					if (cif.multi_sample_convert && cif.gap != '0) begin
						gap_next = cif.gap;
						state_next = dlm_pkg::CS_GAP;
					end else begin
						start_next = 1'b1;
						chan_next = 1'b1;
						state_next = dlm_pkg::CS_SECOND;
					end
				end
			end
			dlm_pkg::CS_GAP: begin
				gap_next = gap_reg - 1'b1;
				if (gap_reg == 16'h0001) begin
					start_next = 1'b1;
					chan_next = 1'b1;
					state_next = dlm_pkg::CS_SECOND;
				end
			end
			dlm_pkg::CS_SECOND: begin
				if (adc_done && !start_reg) begin
					second_next = adc_data;
					done_next = 1'b1;
					state_next = dlm_pkg::CS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= dlm_pkg::CS_IDLE;
			gap_reg <= '0;
			first_reg <= '0;
			second_reg <= '0;
			start_reg <= 1'b0;
			chan_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			gap_reg <= gap_next;
			first_reg <= first_next;
			second_reg <= second_next;
			start_reg <= start_next;
			chan_reg <= chan_next;
			done_reg <= done_next;
		end
	end

	assign adc_start = start_reg;
	assign adc_channel = chan_reg;
	assign cif.busy = (state_reg != dlm_pkg::CS_IDLE) || done_reg;
	assign cif.done = done_reg;
	assign cif.first_data = first_reg;
	assign cif.second_data = second_reg;
endmodule // dlm_conv_seq

// *** logic/dlm_level_track.sv ***
// Per-LED intensity levels and DC tracking values, updated from first-stage samples.
`timescale 1ns/100ps
module dlm_level_track (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample_valid,
	input wire logic sample_is_ir,
	input wire logic [dlm_pkg::ADC_W-1:0] sample,
	input wire logic level_en,
	input wire logic [dlm_pkg::DAC_W-1:0] target_lo,
	input wire logic [dlm_pkg::DAC_W-1:0] target_hi,
	input wire logic [1:0] level_wr,
	input wire logic [dlm_pkg::DAC_W-1:0] level_wdata,
	output logic [dlm_pkg::DAC_W-1:0] level [2],
	output logic [dlm_pkg::DAC_W-1:0] dc [2]
);
	logic [dlm_pkg::DAC_W-1:0] level_reg [2], level_next [2];
	logic [15:0] acc_reg [2], acc_next [2];
	logic signed [16:0] diff;

	// The accumulator carries four fraction bits so small steps are not lost.
	function automatic logic [11:0] step_level(input logic [11:0] lvl, input logic [11:0] s,
		input logic [11:0] lo, input logic [11:0] hi);
		if (s < lo && lvl != 12'hFFF)
			return lvl + dlm_pkg::LEVEL_STEP;
		if (s > hi && lvl != 12'h000)
			return lvl - dlm_pkg::LEVEL_STEP;
		return lvl;
	endfunction

	always_comb begin
		level_next = level_reg;
		acc_next = acc_reg;
		diff = 17'({1'b0, sample, 4'h0}) - 17'({1'b0, acc_reg[sample_is_ir]});
		if (sample_valid) begin
			acc_next[sample_is_ir] = acc_reg[sample_is_ir] + 16'(diff >>> dlm_pkg::DC_SHIFT);
			if (level_en)
				level_next[sample_is_ir] = step_level(level_reg[sample_is_ir], sample,
					target_lo, target_hi);
		end
		for (int i = 0; i < 2; i++) begin
			if (level_wr[i])
				level_next[i] = level_wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= '{dlm_pkg::LEVEL_RESET, dlm_pkg::LEVEL_RESET};
			acc_reg <= '{16'h0000, 16'h0000};
		end else begin
			level_reg <= level_next;
			acc_reg <= acc_next;
		end
	end

	assign level = level_reg;
	assign dc[0] = acc_reg[0][15:4];
	assign dc[1] = acc_reg[1][15:4];
endmodule // dlm_level_track

// *** logic/dlm_sequencer.sv ***
// Red/infrared LED multiplex sequencer with APB register file.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
module dlm_sequencer #(
	parameter int PHASE_CYCLES = dlm_pkg::PHASE_CYCLES,
	parameter int GAP_CYCLES = dlm_pkg::SAMPLE_GAP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dlm_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic adc_start,
	output logic adc_channel,
	input wire logic adc_done,
	input wire logic [dlm_pkg::ADC_W-1:0] adc_data,
	output logic [dlm_pkg::DAC_W-1:0] led_dac_code,
	output logic dac_pin_select,
	output logic dac_pin0_en,
	output logic dac_pin1_en,
	output logic bridge_red,
	output logic bridge_ir,
	output logic [dlm_pkg::DAC_W-1:0] offset_dac_code,
	output logic irq
);
	dlm_conv_if cif ();

	logic [2:0] ctrl_reg, ctrl_next;
	logic [31:0] period_reg, period_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [31:0] target_reg, target_next;
	logic [dlm_pkg::GAP_W-1:0] gap_reg, gap_next;
	logic [31:0] red_data_reg, red_data_next;
	logic [31:0] ir_data_reg, ir_data_next;
	logic [dlm_pkg::EV_W-1:0] int_status_reg, int_status_next;
	logic [dlm_pkg::EV_W-1:0] int_enable_reg, int_enable_next;
	logic [dlm_pkg::EV_W-1:0] ev_set, ev_clr;
	logic led_ir_reg, led_ir_next;
	logic conv_ir_reg, conv_ir_next;
	logic phase_on_reg, phase_on_next;
	logic [dlm_pkg::DAC_W-1:0] led_dac_reg, led_dac_next;
	logic [dlm_pkg::DAC_W-1:0] offset_reg, offset_next;
	logic pin_sel_reg, pin_sel_next;
	logic br_red_reg, br_red_next, br_ir_reg, br_ir_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [dlm_pkg::DAC_W-1:0] level [2];
	logic [dlm_pkg::DAC_W-1:0] dc [2];
	logic [1:0] level_wr;
	logic wr_en, rd_setup, enabled, period_hit, mapped;
	logic [31:0] rd_word;

	// Both data registers share one layout so software reads red and infrared alike.
	function automatic logic [31:0] pack_pair(input logic [dlm_pkg::ADC_W-1:0] first_s,
		input logic [dlm_pkg::ADC_W-1:0] second_s);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[dlm_pkg::DATA_FIRST_LSB +: dlm_pkg::ADC_W] = first_s;
		word[dlm_pkg::DATA_SECOND_LSB +: dlm_pkg::ADC_W] = second_s;
		return word;
	endfunction

	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign enabled = ctrl_reg[dlm_pkg::CTRL_EN_BIT];
	assign period_hit = enabled && (cnt_reg >= period_reg - 32'h0000_0001);

	always_comb begin
		unique case (paddr)
			dlm_pkg::OFS_CTRL, dlm_pkg::OFS_PERIOD, dlm_pkg::OFS_RED_LEVEL,
			dlm_pkg::OFS_IR_LEVEL, dlm_pkg::OFS_RED_DC, dlm_pkg::OFS_IR_DC,
			dlm_pkg::OFS_TARGET, dlm_pkg::OFS_GAP, dlm_pkg::OFS_RED_DATA,
			dlm_pkg::OFS_IR_DATA, dlm_pkg::OFS_INT_STATUS, dlm_pkg::OFS_INT_CLEAR,
			dlm_pkg::OFS_INT_ENABLE, dlm_pkg::OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			dlm_pkg::OFS_CTRL: rd_word = {29'h0, ctrl_reg};
			dlm_pkg::OFS_PERIOD: rd_word = period_reg;
			dlm_pkg::OFS_RED_LEVEL: rd_word = {20'h0, level[0]};
			dlm_pkg::OFS_IR_LEVEL: rd_word = {20'h0, level[1]};
			dlm_pkg::OFS_RED_DC: rd_word = {20'h0, dc[0]};
			dlm_pkg::OFS_IR_DC: rd_word = {20'h0, dc[1]};
			dlm_pkg::OFS_TARGET: rd_word = target_reg;
			dlm_pkg::OFS_GAP: rd_word = {16'h0, gap_reg};
			dlm_pkg::OFS_RED_DATA: rd_word = red_data_reg;
			dlm_pkg::OFS_IR_DATA: rd_word = ir_data_reg;
			dlm_pkg::OFS_INT_STATUS: rd_word = {28'h0, int_status_reg};
			dlm_pkg::OFS_INT_ENABLE: rd_word = {28'h0, int_enable_reg};
			dlm_pkg::OFS_STATUS: rd_word = {29'h0, cif.busy, phase_on_reg, led_ir_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Software level writes go straight into the tracker; red is index 0.
	assign level_wr[0] = wr_en && paddr == dlm_pkg::OFS_RED_LEVEL;
	assign level_wr[1] = wr_en && paddr == dlm_pkg::OFS_IR_LEVEL;

	// Register file and bus answer.
	always_comb begin
		ctrl_next = ctrl_reg;
		period_next = period_reg;
		target_next = target_reg;
		gap_next = gap_reg;
		int_enable_next = int_enable_reg;
		ev_clr = '0;
		prdata_next = prdata_reg;
		if (rd_setup)
			prdata_next = rd_word;
		if (wr_en) begin
			unique case (paddr)
				dlm_pkg::OFS_CTRL: ctrl_next = pwdata[2:0];
				dlm_pkg::OFS_PERIOD: period_next = (pwdata == 32'h0) ? 32'h1 : pwdata;
				dlm_pkg::OFS_TARGET: target_next = pwdata & 32'h0FFF_0FFF;
				dlm_pkg::OFS_GAP: gap_next = pwdata[15:0];
				dlm_pkg::OFS_INT_CLEAR: ev_clr = pwdata[3:0];
				dlm_pkg::OFS_INT_ENABLE: int_enable_next = pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Phase sequencing: each period event opens a phase for the other LED.
	always_comb begin
		cnt_next = cnt_reg;
		led_ir_next = led_ir_reg;
		conv_ir_next = conv_ir_reg;
		phase_on_next = phase_on_reg;
		led_dac_next = led_dac_reg;
		offset_next = offset_reg;
		pin_sel_next = pin_sel_reg;
		br_red_next = br_red_reg;
		br_ir_next = br_ir_reg;
		red_data_next = red_data_reg;
		ir_data_next = ir_data_reg;
		ev_set = '0;
		cif.start = 1'b0;
		if (!enabled) begin
			cnt_next = '0;
			phase_on_next = 1'b0;
			led_dac_next = '0;
			br_red_next = 1'b0;
			br_ir_next = 1'b0;
		end else if (period_hit) begin
			cnt_next = '0;
			led_ir_next = !led_ir_reg;
			phase_on_next = 1'b1;
			pin_sel_next = !led_ir_reg;
			br_red_next = led_ir_reg;
			br_ir_next = !led_ir_reg;
			led_dac_next = level[!led_ir_reg];
			offset_next = dc[!led_ir_reg];
			ev_set[dlm_pkg::EV_PHASE] = 1'b1;
			// A phase that finds the converter still busy skips its samples.
			if (cif.busy) begin
				ev_set[dlm_pkg::EV_OVERRUN] = 1'b1;
			end else begin
				cif.start = 1'b1;
				conv_ir_next = !led_ir_reg;
			end
		end else begin
			cnt_next = cnt_reg + 32'h0000_0001;
		end
		if (cif.done) begin
			if (conv_ir_reg) begin
				ir_data_next = pack_pair(cif.first_data, cif.second_data);
				ev_set[dlm_pkg::EV_DONE_IR] = 1'b1;
			end else begin
				red_data_next = pack_pair(cif.first_data, cif.second_data);
				ev_set[dlm_pkg::EV_DONE_RED] = 1'b1;
			end
			// The new phase keeps its intensity if both land together.
			if (!period_hit)
				led_dac_next = '0;
		end
	end

	// Sticky events: a set in the same cycle as its clear wins.
	always_comb begin
		int_status_next = (int_status_reg & ~ev_clr) | ev_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= dlm_pkg::CTRL_RESET;
			period_reg <= 32'(PHASE_CYCLES);
			target_reg <= dlm_pkg::TARGET_RESET;
			gap_reg <= 16'(GAP_CYCLES);
			int_enable_reg <= '0;
			int_status_reg <= '0;
			prdata_reg <= '0;
			cnt_reg <= '0;
			led_ir_reg <= 1'b1;
			conv_ir_reg <= 1'b0;
			phase_on_reg <= 1'b0;
			led_dac_reg <= '0;
			offset_reg <= '0;
			pin_sel_reg <= 1'b0;
			br_red_reg <= 1'b0;
			br_ir_reg <= 1'b0;
			red_data_reg <= '0;
			ir_data_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			period_reg <= period_next;
			target_reg <= target_next;
			gap_reg <= gap_next;
			int_enable_reg <= int_enable_next;
			int_status_reg <= int_status_next;
			prdata_reg <= prdata_next;
			cnt_reg <= cnt_next;
			led_ir_reg <= led_ir_next;
			conv_ir_reg <= conv_ir_next;
			phase_on_reg <= phase_on_next;
			led_dac_reg <= led_dac_next;
			offset_reg <= offset_next;
			pin_sel_reg <= pin_sel_next;
			br_red_reg <= br_red_next;
			br_ir_reg <= br_ir_next;
			red_data_reg <= red_data_next;
			ir_data_reg <= ir_data_next;
		end
	end

	assign cif.multi_sample_convert = ctrl_reg[dlm_pkg::CTRL_MSC_BIT];
	assign cif.gap = gap_reg;

	dlm_conv_seq u_conv (
		.pclk(pclk),
		.presetn(presetn),
		.cif(cif),
		.adc_start(adc_start),
		.adc_channel(adc_channel),
		.adc_done(adc_done),
		.adc_data(adc_data)
	);

	dlm_level_track u_track (
		.pclk(pclk),
		.presetn(presetn),
		.sample_valid(cif.done),
		.sample_is_ir(conv_ir_reg),
		.sample(cif.first_data),
		.level_en(ctrl_reg[dlm_pkg::CTRL_LEVEL_BIT]),
		.target_lo(target_reg[dlm_pkg::TGT_LO_LSB +: dlm_pkg::DAC_W]),
		.target_hi(target_reg[dlm_pkg::TGT_HI_LSB +: dlm_pkg::DAC_W]),
		.level_wr(level_wr),
		.level_wdata(pwdata[11:0]),
		.level(level),
		.dc(dc)
	);

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign led_dac_code = led_dac_reg;
	assign offset_dac_code = offset_reg;
	assign dac_pin_select = pin_sel_reg;
	// Unselected DAC pin is released to high impedance.
	assign dac_pin0_en = phase_on_reg && !pin_sel_reg;
	assign dac_pin1_en = phase_on_reg && pin_sel_reg;
	assign bridge_red = br_red_reg && !br_ir_reg;
	assign bridge_ir = br_ir_reg;
	assign irq = |(int_status_reg & int_enable_reg);
endmodule // dlm_sequencer

// *** testbench/dlm_probe_model.sv ***
// Converter and probe front end model answering sample requests.
`timescale 1ns/100ps
module dlm_probe_model #(
	parameter int LATENCY = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire logic adc_channel,
	input wire logic bridge_ir,
	output logic adc_done,
	output logic [dlm_pkg::ADC_W-1:0] adc_data
);
	int cnt;
	logic chan;
	logic ir;
	// Red first stage sits below the target range and infrared above it.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			chan <= 1'b0;
			ir <= 1'b0;
			adc_done <= 1'b0;
			adc_data <= 12'h000;
		end else begin
			adc_done <= (cnt == 1);
			if (cnt == 1) begin
				adc_data <= chan ? (ir ? 12'h222 : 12'h111) : (ir ? 12'hC00 : 12'h400);
			end else begin
				// Data is only valid with the done pulse, so it churns otherwise.
				adc_data <= ~adc_data;
			end
			if (adc_start) begin
				cnt <= LATENCY;
				chan <= adc_channel;
				ir <= bridge_ir;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // dlm_probe_model

// *** testbench/dlm_sequencer_sva.sv ***
// Concurrent checks on the ports of the LED multiplex sequencer.
`timescale 1ns/100ps
module dlm_sequencer_sva #(
	parameter int PHASE_CYCLES = 200,
	parameter int GAP_CYCLES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire logic adc_channel,
	input wire logic adc_done,
	input wire logic [dlm_pkg::DAC_W-1:0] led_dac_code,
	input wire logic dac_pin_select,
	input wire logic dac_pin0_en,
	input wire logic dac_pin1_en,
	input wire logic bridge_red,
	input wire logic bridge_ir
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_bridge_excl: assert property (!(bridge_red && bridge_ir))
		else $error("both bridge outputs on");
	a_pin_excl: assert property (!(dac_pin0_en && dac_pin1_en))
		else $error("both DAC pins driven");
	a_pin_follow: assert property ((dac_pin0_en || dac_pin1_en) |-> dac_pin1_en == dac_pin_select)
		else $error("driven DAC pin differs from select");
	a_phase_select: assert property (($rose(bridge_red) || $rose(bridge_ir)) |-> dac_pin_select == bridge_ir)
		else $error("pin select does not match lit LED");
	a_phase_start: assert property (($rose(bridge_red) || $rose(bridge_ir)) |-> adc_start && !adc_channel)
		else $error("phase did not start first stage sample");
	a_second_sample: assert property ((adc_done && !adc_channel) |-> ##[1:12] (adc_start && adc_channel))
		else $error("second stage sample missing");
	a_led_off: assert property ((adc_done && adc_channel) |-> ##[1:3] (led_dac_code == 12'h000))
		else $error("LED current not removed after conversion");
	a_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("sample request longer than one cycle");
	a_phase_hold: assert property ($rose(bridge_red) |=> bridge_red [*8])
		else $error("red phase cut short");
	a_led_lit: assert property ((led_dac_code != 12'h000) |-> (bridge_red || bridge_ir))
		else $error("LED current without bridge path");
endmodule // dlm_sequencer_sva
bind dlm_sequencer dlm_sequencer_sva #(.PHASE_CYCLES(PHASE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_sva (
	.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_channel(adc_channel),
	.adc_done(adc_done), .led_dac_code(led_dac_code), .dac_pin_select(dac_pin_select),
	.dac_pin0_en(dac_pin0_en), .dac_pin1_en(dac_pin1_en), .bridge_red(bridge_red),
	.bridge_ir(bridge_ir));

// *** testbench/dlm_sequencer_tb.sv ***
// Self-checking testbench for the LED multiplex sequencer.
`timescale 1ns/100ps
module dlm_sequencer_tb;
	localparam int PER = 60;
	localparam int LAT = 3;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, adc_start, adc_channel, adc_done, irq;
	logic [11:0] adc_data, led_dac_code, offset_dac_code;
	logic dac_pin_select, dac_pin0_en, dac_pin1_en, bridge_red, bridge_ir;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	dlm_sequencer #(.PHASE_CYCLES(PER), .GAP_CYCLES(4)) u_dlm_sequencer (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
		.adc_data(adc_data), .led_dac_code(led_dac_code), .dac_pin_select(dac_pin_select),
		.dac_pin0_en(dac_pin0_en), .dac_pin1_en(dac_pin1_en), .bridge_red(bridge_red),
		.bridge_ir(bridge_ir), .offset_dac_code(offset_dac_code), .irq(irq));
	dlm_probe_model #(.LATENCY(LAT)) u_dlm_probe_model (.pclk(pclk), .presetn(presetn),
		.adc_start(adc_start), .adc_channel(adc_channel), .bridge_ir(bridge_ir),
		.adc_done(adc_done), .adc_data(adc_data));
	always #5 pclk = ~pclk;
	task automatic print_verdict();
		if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// The ceiling covers the whole sequence with wide margin.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] x;
		logic e;
		apb(1'b0, a, 32'h0, x, e);
		check(nm, x, exp);
	endtask
	task automatic wait_hi(input int k, output int t);
		while ((k == 0 ? bridge_red : k == 1 ? bridge_ir : irq) !== 1'b1) begin
			@(posedge pclk);
			#1;
		end
		t = cyc;
	endtask
	task automatic t_reset();
		logic [31:0] x;
		logic e;
		check("bridge idle", {bridge_red, bridge_ir, led_dac_code}, 32'h0);
		rdc(dlm_pkg::OFS_CTRL, 32'h2, "ctrl reset");
		rdc(dlm_pkg::OFS_RED_LEVEL, 32'h800, "red level reset");
		rdc(dlm_pkg::OFS_TARGET, 32'h0A00_0600, "target reset");
		apb(1'b0, 8'h40, 32'h0, x, e);
		check("unmapped", {e, x[30:0]}, 32'h8000_0000);
	endtask
	// Runs a full red and infrared round, then the next red phase and infrared phase start, with level tracking on.
	task automatic t_run();
		int t0, t1, t2;
		wr(dlm_pkg::OFS_PERIOD, PER);
		wr(dlm_pkg::OFS_GAP, 32'h4);
		wr(dlm_pkg::OFS_RED_LEVEL, 32'h123);
		wr(dlm_pkg::OFS_IR_LEVEL, 32'h456);
		wr(dlm_pkg::OFS_INT_ENABLE, 32'h6);
		wr(dlm_pkg::OFS_CTRL, 32'h7);
		wait_hi(0, t0);
		check("red phase", {dac_pin_select, dac_pin0_en, dac_pin1_en}, 32'h2);
		check("red level", led_dac_code, 32'h123);
		check("red offset", offset_dac_code, 32'h0);
		wait_hi(2, t2);
		check("led off", led_dac_code, 32'h0);
		rdc(dlm_pkg::OFS_RED_DATA, 32'h0400_0111, "red data");
		rdc(dlm_pkg::OFS_INT_STATUS, 32'h3, "red status");
		wr(dlm_pkg::OFS_INT_CLEAR, 32'hF);
		#1;
		check("irq cleared", irq, 32'h0);
		rdc(dlm_pkg::OFS_RED_DC, 32'h040, "red dc");
		wait_hi(1, t1);
		check("phase length", t1 - t0, PER);
		check("ir phase", {dac_pin_select, dac_pin0_en, dac_pin1_en}, 32'h5);
		check("ir level", led_dac_code, 32'h456);
		wait_hi(2, t2);
		rdc(dlm_pkg::OFS_IR_DATA, 32'h0C00_0222, "ir data");
		wr(dlm_pkg::OFS_INT_CLEAR, 32'hF);
		wait_hi(0, t2);
		check("second stage rate", t2 - t1, PER);
		check("red level up", led_dac_code, 32'h124);
		check("red offset dc", offset_dac_code, 32'h040);
		wait_hi(1, t1);
		check("ir level down", led_dac_code, 32'h455);
	endtask
	task automatic t_mask();
		int t;
		wr(dlm_pkg::OFS_INT_ENABLE, 32'h0);
		wr(dlm_pkg::OFS_INT_CLEAR, 32'hF);
		wait_hi(0, t);
		wait_hi(1, t);
		check("irq masked", irq, 32'h0);
		wr(dlm_pkg::OFS_INT_ENABLE, 32'h2);
		#1;
		check("irq unmasked", irq, 32'h1);
		wr(dlm_pkg::OFS_INT_CLEAR, 32'h2);
		#1;
		check("irq clear", irq, 32'h0);
	endtask
	// Direct sampling without the gap timer, then a disable that must darken the probe.
	task automatic t_modes();
		int t0, t1;
		wr(dlm_pkg::OFS_CTRL, 32'h1);
		wr(dlm_pkg::OFS_INT_CLEAR, 32'hF);
		wait_hi(0, t0);
		wait_hi(2, t1);
		check("direct sample time", t1 - t0, 2 * LAT + 5);
		rdc(dlm_pkg::OFS_RED_DATA, 32'h0400_0111, "red data direct");
		rdc(dlm_pkg::OFS_STATUS, 32'h2, "status red phase");
		wr(dlm_pkg::OFS_CTRL, 32'h0);
		@(posedge pclk);
		#1;
		check("disabled dark", {bridge_red, bridge_ir, dac_pin0_en, dac_pin1_en,
			led_dac_code}, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_run();
		t_mask();
		t_modes();
		print_verdict();
	end
endmodule // dlm_sequencer_tb
